/* File: bench/testbench.sv */
// Self-checking bench: firmware over APB, host model on the SIE side.
// Assumes one APB wait state and the strobe timing of the hand-over.
`timescale 1ns/1ns
`define CHK(n, e, g) begin \
   n_compared++; \
   if ((g) !== (e)) begin \
      num_errors++; \
      $display("Error %s expected %0h seen %0h", n, e, g); \
   end \
end
module testbench
   import uef_pkg::*;
;
   localparam logic [1:0] NONE = 2'h3;
   typedef struct {int op; int val; logic [1:0] hs; logic [7:0] sta;
      int cnt;} uef_row_t;
   logic CLK = 1'b0;
   logic RST_N = 1'b0;
   logic PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0;
   logic [7:0] PADDR = 8'h00;
   logic [31:0] PWDATA = 32'h0, PRDATA, d;
   logic PREADY, PSLVERR, TOK_VALID, RX_VALID, RX_END, RX_CRC_OK;
   logic RX_DATA1, TX_ACK_IN, HS_VALID, TX_VALID, TX_END, slverr, fin;
   logic [1:0] TOK_PID, HS_CODE, hs;
   logic [7:0] RX_DATA, TX_DATA;
   int num_errors = 0, n_compared = 0;
   logic [7:0] ra [4] = '{A_CFG, A_STA, A_CNTL, A_CNTH};
   // Ping-pong bulk OUT: 0 good, 1 bad CRC, 2 pop, 3 status, 4 clear
   uef_row_t rows [11] = '{
      '{0, 3, HS_ACK, 8'h02, 3}, '{0, 0, HS_ACK, 8'h42, 3},
      '{0, 2, HS_NAK, 8'h42, 3}, '{2, 3, NONE, 8'h42, -1},
      '{3, 32'h40, NONE, 8'h40, 0}, '{0, 70, HS_ACK, 8'h42, 0},
      '{3, 32'h02, NONE, 8'h02, 70}, '{2, 64, NONE, 8'h02, -1},
      '{4, 0, NONE, 8'h02, 0}, '{1, 4, NONE, 8'h02, -1},
      '{3, 0, NONE, 8'h00, -1}};

   always #50 CLK = ~CLK;

   uef_endpoint DUT (.CLK, .RST_N, .PSEL, .PENABLE, .PWRITE, .PADDR,
      .PWDATA, .PRDATA, .PREADY, .PSLVERR, .TOK_VALID, .TOK_PID,
      .RX_VALID, .RX_DATA, .RX_END, .RX_CRC_OK, .RX_DATA1, .TX_ACK_IN,
      .HS_VALID, .HS_CODE, .TX_VALID, .TX_DATA, .TX_END);

   uef_host host (.clk(CLK), .tok_valid(TOK_VALID), .tok_pid(TOK_PID),
      .rx_valid(RX_VALID), .rx_data(RX_DATA), .rx_end(RX_END),
      .rx_crc_ok(RX_CRC_OK), .rx_data1(RX_DATA1), .tx_ack_in(TX_ACK_IN),
      .hs_valid(HS_VALID), .hs_code(HS_CODE), .tx_valid(TX_VALID),
      .tx_data(TX_DATA), .tx_end(TX_END));

   task automatic end_of_test();
      $display("Comparisons %0d, errors %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   // One APB transfer; request held until PREADY is sampled high
   task automatic apb(input logic w, input logic [7:0] a,
         input logic [31:0] wd);
      int k;
      @(posedge CLK);
      PSEL <= 1'b1;
      PWRITE <= w;
      PADDR <= a;
      PWDATA <= wd;
      @(posedge CLK);
      PENABLE <= 1'b1;
      for (k = 0; k < 20; k++) begin
         @(posedge CLK);
         if (PREADY === 1'b1) break;
      end
      if (k == 20) begin
         num_errors++;
         end_of_test();
      end
      d = PRDATA;
      slverr = PSLVERR;
      PSEL <= 1'b0;
      PENABLE <= 1'b0;
      PWDATA <= ~wd;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      apb(1'b1, a, v);
   endtask

   task automatic rd(input logic [7:0] a);
      apb(1'b0, a, 32'h0);
   endtask

   task automatic pop(input int n);
      for (int i = 0; i < n; i++) begin
         rd(A_DAT);
         `CHK("fifo byte", 8'hA0 + i[7:0], d[7:0])
      end
   endtask

   // Hang guard
   initial begin
      repeat (100000) @(posedge CLK);
      num_errors++;
      end_of_test();
   end

   // Main sequence
   initial begin
      repeat (16) @(posedge CLK);
      RST_N <= 1'b1;
      host.send(PID_OUT, 1, 1'b1, hs);
      `CHK("off hs", NONE, hs)
      foreach (ra[i]) begin
         rd(ra[i]);
         `CHK("reset value", 32'h0, d)
      end
      rd(8'h18);
      `CHK("unmapped err", 1'b1, slverr)
      wr(A_CFG, 32'h92);
      foreach (rows[r]) begin
         case (rows[r].op)
            0, 1: begin
               host.send(PID_OUT, rows[r].val, rows[r].op == 0, hs);
               `CHK("handshake", rows[r].hs, hs)
            end
            2: pop(rows[r].val);
            3: wr(A_STA, rows[r].val);
            default: begin
               wr(A_CLR, 32'h1);
               wr(A_CLR, 32'h0);
            end
         endcase
         rd(A_STA);
         `CHK("status", rows[r].sta, d[7:0])
         if (rows[r].cnt >= 0) begin
            rd(A_CNTL);
            `CHK("count", rows[r].cnt[7:0], d[7:0])
         end
      end
      rd(A_CFG);
      `CHK("toggle", 1'b0, d[CFG_TGL])
      // Standard IN: NAK, send, retry, zero length, cancel
      wr(A_CFG, 32'h86);
      host.in_req(1'b1, hs, fin);
      `CHK("in nak", HS_NAK, hs)
      for (int i = 1; i < 4; i++) wr(A_DAT, 32'h11 * i);
      wr(A_STA, 32'h10);
      host.in_req(1'b0, hs, fin);
      `CHK("in bytes", 3, host.got.size())
      host.in_req(1'b1, hs, fin);
      `CHK("retry last", 8'h33, host.got[2])
      rd(A_STA);
      `CHK("sent", 8'h01, d[7:0])
      wr(A_STA, 32'h0);
      wr(A_STA, 32'h10);
      host.in_req(1'b1, hs, fin);
      `CHK("zlp end", 1'b1, fin)
      `CHK("zlp size", 0, host.got.size())
      wr(A_STA, 32'h0);
      wr(A_DAT, 32'h77);
      wr(A_STA, 32'h10);
      wr(A_STA, 32'h0);
      wr(A_DAT, 32'h55);
      wr(A_STA, 32'h10);
      host.in_req(1'b1, hs, fin);
      `CHK("cancel", 8'h55, host.got[0])
      `CHK("cancel n", 1, host.got.size())
      wr(A_STA, 32'h0);
      // Ping-pong IN: both banks armed, then drained
      wr(A_CFG, 32'h96);
      host.in_req(1'b1, hs, fin);
      `CHK("pp nak", HS_NAK, hs)
      for (int i = 0; i < 2; i++) begin
         wr(A_DAT, 32'h61 + i);
         wr(A_STA, 32'h10);
      end
      for (int i = 0; i < 2; i++) begin
         host.in_req(1'b1, hs, fin);
         `CHK("pp byte", 8'h61 + i[7:0], host.got[0])
      end
      host.in_req(1'b1, hs, fin);
      `CHK("pp empty", HS_NAK, hs)
      wr(A_STA, 32'h0);
      // Control: SETUP over armed IN, then status OUT
      wr(A_CFG, 32'h80);
      wr(A_STA, 32'h80);
      wr(A_DAT, 32'h01);
      wr(A_STA, 32'h90);
      host.send(PID_SETUP, 8, 1'b1, hs);
      `CHK("setup hs", HS_ACK, hs)
      rd(A_STA);
      `CHK("setup sta", 8'h04, d[7:0])
      rd(A_CNTL);
      `CHK("setup cnt", 8'h08, d[7:0])
      pop(8);
      wr(A_STA, 32'h0);
      host.send(PID_OUT, 0, 1'b1, hs);
      `CHK("status out", HS_ACK, hs)
      host.send(PID_OUT, 2, 1'b1, hs);
      `CHK("full nak", HS_NAK, hs)
      rd(A_STA);
      `CHK("ctl sta", 8'h02, d[7:0])
      wr(A_STA, 32'h0);
      // Isochronous OUT: bad CRC, refresh, silent drop
      wr(A_CFG, 32'h81);
      host.send(PID_OUT, 2, 1'b0, hs);
      rd(A_STA);
      `CHK("iso crc", 8'h0A, d[7:0])
      pop(2);
      wr(A_STA, 32'h08);
      host.send(PID_OUT, 3, 1'b1, hs);
      `CHK("iso hs", NONE, hs)
      rd(A_STA);
      `CHK("iso sta", 8'h02, d[7:0])
      host.send(PID_OUT, 4, 1'b1, hs);
      rd(A_CNTL);
      `CHK("iso drop", 8'h03, d[7:0])
      pop(3);
      // Second reset in mid-run
      RST_N <= 1'b0;
      repeat (2) @(posedge CLK);
      RST_N <= 1'b1;
      rd(A_CFG);
      `CHK("cfg after reset", 32'h0, d)
      end_of_test();
   end
endmodule

/* File: bench/uef_host.sv */
// Host side model: tokens, OUT data packets and IN acknowledges.
// Assumes an endpoint that samples these strobes on the rising clk.
`timescale 1ns/1ns
module uef_host
   import uef_pkg::*;
(
   input wire logic clk,
   output logic tok_valid,
   output logic [1:0] tok_pid,
   output logic rx_valid,
   output logic [7:0] rx_data,
   output logic rx_end,
   output logic rx_crc_ok,
   output logic rx_data1,
   output logic tx_ack_in,
   input wire logic hs_valid,
   input wire logic [1:0] hs_code,
   input wire logic tx_valid,
   input wire logic [7:0] tx_data,
   input wire logic tx_end
);
   logic [7:0] got [$];
   // Bus idle at time zero
   initial begin
      {tok_valid, rx_valid, rx_end, tx_ack_in} = 4'h0;
      tok_pid = 2'h3;
      rx_data = 8'h5A;
      rx_crc_ok = 1'b0;
      rx_data1 = 1'b1;
   end
   // Token, n bytes A0 upward, end marker; 2'h3 means no handshake
   task automatic send(input logic [1:0] pid, input int n,
         input logic crc, output logic [1:0] hs);
      @(posedge clk);
      tok_valid <= 1'b1;
      tok_pid <= pid;
      for (int i = 0; i < n; i++) begin
         @(posedge clk);
         tok_valid <= 1'b0;
         rx_valid <= 1'b1;
         rx_data <= 8'hA0 + i[7:0];
      end
      @(posedge clk);
      tok_valid <= 1'b0;
      rx_valid <= 1'b0;
      rx_data <= ~rx_data;
      rx_end <= 1'b1;
      rx_crc_ok <= crc;
      rx_data1 <= 1'b0;
      @(posedge clk);
      rx_end <= 1'b0;
      rx_crc_ok <= ~crc;
      rx_data1 <= 1'b1;
      hs = 2'h3;
      repeat (4) begin
         @(posedge clk);
         if (hs_valid === 1'b1) hs = hs_code;
      end
   endtask
   // IN token; bytes land in got; a complete packet may be acknowledged
   task automatic in_req(input logic ack, output logic [1:0] hs,
         output logic fin);
      @(posedge clk);
      tok_valid <= 1'b1;
      tok_pid <= PID_IN;
      @(posedge clk);
      tok_valid <= 1'b0;
      got.delete();
      hs = 2'h3;
      fin = 1'b0;
      for (int k = 0; k < 90 && hs === 2'h3 && !fin; k++) begin
         @(posedge clk);
         if (tx_valid === 1'b1) got.push_back(tx_data);
         if (hs_valid === 1'b1) hs = hs_code;
         fin = (tx_end === 1'b1);
      end
      if (fin && ack) begin
         tx_ack_in <= 1'b1;
         @(posedge clk);
         tx_ack_in <= 1'b0;
      end
   endtask
endmodule

/* File: design/uef_endpoint.sv */
// One USB endpoint: OUT/IN/SETUP handshakes, flags, byte counts, FIFO.
// Assumes SIE strobes synchronous to CLK and an APB master on the bus.
// Contract
// R1 - Valid OUT sets the full flag of its bank
// R2 - Byte count shown; zero packet reads zero
// R3 - Firmware empties bank; clearing swaps banks
// R4 - Full bank makes OUT answer NAK
// R5 - Bank full flags set alternately
// R6 - NAK only when both banks still full
// R7 - Excess bytes dropped, packet still valid
// R8 - Firmware loads FIFO then arms packet
// R9 - IN answered NAK until packet armed
// R10 - Disarming cancels packet and empties FIFO; code cancels in standard mode only, and not during S_TX or S_WACK
// R11 - Acknowledged IN sets sent flag
// R12 - Firmware clears sent flag before refilling
// R13 - IN retries handled by hardware alone
// R14 - Arming switches firmware bank on ping-pong
// R15 - Ping-pong IN NAKs each unarmed bank
// R16 - Firmware clears sent before arming
// R17 - SETUP sets its flag, clears the others
// R18 - Firmware reads SETUP before clearing flag
// R19 - Control full-duplex; direction bit for IN
// R20 - Direction bit zero in setup, status
// R21 - Status stage is zero-length packet
// R22 - Isochronous OUT refreshes CRC error flag
// R23 - Full isochronous bank drops data silently
// R24 - Disabled endpoint ignores all tokens
// R25 - FIFO clear resets pointers, count, toggle
// R26 - Flags sticky; hardware set beats clear
`timescale 1ns/1ns
module uef_endpoint
   import uef_pkg::*;
#(
   parameter int FIFO_DEPTH = 64,
   parameter int CNT_W = 11,
   parameter bit IS_DEFAULT = 1'b0
) (
   input wire logic CLK,
   input wire logic RST_N,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [7:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   input wire logic TOK_VALID,
   input wire logic [1:0] TOK_PID,
   input wire logic RX_VALID,
   input wire logic [7:0] RX_DATA,
   input wire logic RX_END,
   input wire logic RX_CRC_OK,
   input wire logic RX_DATA1,
   input wire logic TX_ACK_IN,
   output logic HS_VALID,
   output logic [1:0] HS_CODE,
   output logic TX_VALID,
   output logic [7:0] TX_DATA,
   output logic TX_END
);
   localparam int AW = $clog2(FIFO_DEPTH);
   localparam logic [AW:0] DEPTH_C = FIFO_DEPTH[AW:0];

   uef_state_t st;
   logic [7:0] mem [0:2*FIFO_DEPTH-1];
   logic cfg_on, cfg_pp, cfg_dir, tgl, way;
   logic [1:0] cfg_type;
   logic [1:0] full, arm, b_set, b_clr;
   logic setup, crc, sent;
   logic fw_bank, tx_bank, rx_bank, rd_bank;
   logic [AW-1:0] rd_ptr;
   logic [AW:0] wcnt [0:1];
   logic [CNT_W-1:0] cnt [0:1];
   logic rx_tgt, rx_nak, rx_setup, rx_took;
   logic [CNT_W-1:0] rx_len;
   logic [AW:0] rx_wp, tx_ptr;
   logic [31:0] rd_mux;
   logic hit;

   // Bus strobes: effects happen only on the edge that sees PREADY
   logic acc, wr, rd, sw, fw_wr, fifo_rd, fifo_clr;
   assign acc = PSEL & PENABLE & PREADY;
   assign wr = acc & PWRITE;
   assign rd = acc & !PWRITE;
   assign sw = wr & (PADDR == A_STA);
   assign fifo_rd = rd & (PADDR == A_DAT);
   assign fifo_clr = wr & (PADDR == A_CLR) & PWDATA[CLR_BIT];

   // Endpoint kind
   logic en, ctrl, iso, pp, out_ok, in_ok;
   assign en = cfg_on | IS_DEFAULT; // [R24]
   assign ctrl = (cfg_type == TY_CTRL);
   assign iso = (cfg_type == TY_ISO);
   assign pp = cfg_pp & !ctrl;
   assign out_ok = ctrl | !cfg_dir; // [R19]
   assign in_ok = ctrl | cfg_dir; // [R19]

   // OUT bank choice: the free bank; ping-pong NAKs only if neither is free, standard non-isochronous if bank 0 is full
   logic pick, nak_out, tgt_out;
   assign pick = full[rx_bank] ? ~rx_bank : rx_bank; // [R6]
   assign nak_out = pp ? &full : (full[0] & !iso); // [R4] [R6] [R23]
   assign tgt_out = pp & pick;

   // Receive events
   logic rx_store, end_rx, good, setup_done, iso_done, ack_in;
   assign rx_store = (st == S_RX) & RX_VALID & !rx_nak
      & (rx_setup | !full[rx_tgt]) & (rx_wp < DEPTH_C); // [R7] [R23]
   assign end_rx = (st == S_RX) & RX_END;
   assign good = end_rx & RX_CRC_OK & !rx_nak & (!iso | rx_setup);
   assign setup_done = good & rx_setup; // [R17]
   assign iso_done = end_rx & iso & !rx_setup & (rx_took | !full[0]);
   assign ack_in = (st == S_WACK) & TX_ACK_IN;

   // IN side events; a write during an OUT store is dropped
   logic arming, cancel;
   assign arming = sw & PWDATA[ST_ARM] & !arm[fw_bank];
   assign cancel = sw & !PWDATA[ST_ARM] & !pp & arm[0]
      & (st != S_TX) & (st != S_WACK); // [R10]
   assign fw_wr = wr & (PADDR == A_DAT) & !rx_store
      & (wcnt[fw_bank] < DEPTH_C);

   // Register read mux
   always_comb begin
      rd_mux = 32'h0;
      hit = 1'b1;
      case (PADDR)
         A_CFG: begin
            rd_mux[CFG_ON] = cfg_on;
            rd_mux[CFG_PP] = cfg_pp;
            rd_mux[CFG_TGL] = tgl;
            rd_mux[CFG_DIR] = cfg_dir;
            rd_mux[CFG_TY +: 2] = cfg_type;
         end
         A_STA: begin
            rd_mux[ST_SENT] = sent;
            rd_mux[ST_B0] = full[0];
            rd_mux[ST_SETUP] = setup;
            rd_mux[ST_CRC] = crc;
            rd_mux[ST_ARM] = pp ? |arm : arm[0];
            rd_mux[ST_B1] = full[1];
            rd_mux[ST_WAY] = way;
         end
         A_CNTL: rd_mux[BYTE_W-1:0] = cnt[rd_bank][BYTE_W-1:0]; // [R2]
         A_CNTH: rd_mux[CNT_W-BYTE_W-1:0] = cnt[rd_bank][CNT_W-1:BYTE_W];
         A_DAT: rd_mux[BYTE_W-1:0] = mem[{rd_bank, rd_ptr}];
         A_CLR: rd_mux = 32'h0;
         default: hit = 1'b0;
      endcase
   end

   // APB slave: one wait state, read data caught before PREADY
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         PREADY <= 1'b0;
         PRDATA <= 32'h0;
         PSLVERR <= 1'b0;
      end else begin
         PREADY <= PSEL & PENABLE & !PREADY;
         PSLVERR <= PSEL & PENABLE & !PREADY & !hit;
         if (PSEL & PENABLE & !PREADY) begin
            PRDATA <= PWRITE ? 32'h0 : rd_mux;
         end
      end
   end

   // Endpoint configuration; default endpoint resets to control
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         cfg_on <= 1'b0;
         cfg_pp <= 1'b0;
         cfg_dir <= 1'b0;
         cfg_type <= TY_CTRL;
      end else if (wr & (PADDR == A_CFG)) begin
         cfg_on <= PWDATA[CFG_ON];
         cfg_pp <= PWDATA[CFG_PP];
         cfg_dir <= PWDATA[CFG_DIR];
         cfg_type <= PWDATA[CFG_TY +: 2];
      end
   end

   // Per-bank full flags and byte counts; set wins over clear
   for (genvar b = 0; b < 2; b++) begin : g_bank
      localparam int FB = b ? ST_B1 : ST_B0;
      assign b_set[b] = (good & !rx_setup & (rx_tgt == b))
         | (iso_done & (b == 0)); // [R1] [R22]
      assign b_clr[b] = sw & !PWDATA[FB];
      always_ff @(posedge CLK or negedge RST_N) begin
         if (!RST_N) begin
            full[b] <= 1'b0;
            cnt[b] <= '0;
         end else begin
            full[b] <= !setup_done & (b_set[b] | (full[b] & !b_clr[b])); // [R26] [R17]
            if (b_set[b] | (setup_done & (b == 0))) begin
               cnt[b] <= rx_len; // [R2] [R7]
            end else if (fifo_clr) begin
               cnt[b] <= '0; // [R25]
            end
         end
      end
   end

   // Status flags, bank pointers and FIFO pointers
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         setup <= 1'b0;
         crc <= 1'b0;
         sent <= 1'b0;
         way <= 1'b0;
         tgl <= 1'b0;
         arm <= 2'h0;
         fw_bank <= 1'b0;
         tx_bank <= 1'b0;
         rx_bank <= 1'b0;
         rd_bank <= 1'b0;
         rd_ptr <= '0;
         wcnt[0] <= '0;
         wcnt[1] <= '0;
      end else begin
         setup <= setup_done | (setup & !(sw & !PWDATA[ST_SETUP])); // [R26]
         if (iso_done) begin
            crc <= !RX_CRC_OK; // [R22]
         end else begin
            crc <= !setup_done & crc & !(sw & !PWDATA[ST_CRC]);
         end
         sent <= ack_in | (!setup_done & sent & !(sw & !PWDATA[ST_SENT])); // [R11]
         if (setup_done) begin
            way <= 1'b0; // [R17]
         end else if (sw) begin
            way <= PWDATA[ST_WAY]; // [R19]
         end
         if (fifo_clr) begin
            tgl <= 1'b0; // [R25]
         end else if (good) begin
            tgl <= !RX_DATA1;
         end
         if (setup_done) begin
            arm <= 2'h0; // [R17]
         end else begin
            if (ack_in) arm[tx_bank] <= 1'b0;
            if (arming) arm[fw_bank] <= 1'b1;
            if (cancel) arm[0] <= 1'b0; // [R10]
         end
         if (arming & pp) fw_bank <= ~fw_bank; // [R14]
         if (ack_in & pp) tx_bank <= ~tx_bank;
         if (good & pp & !rx_setup) rx_bank <= ~rx_tgt; // [R5]
         // Releasing the read bank hands firmware the other one in ping-pong mode
         if ((b_clr[rd_bank] & full[rd_bank]) | setup_done | fifo_clr) begin
            rd_ptr <= '0; // [R25]
            if (pp & b_clr[rd_bank] & full[rd_bank] & !fifo_clr) begin
               rd_bank <= ~rd_bank; // [R3]
            end
         end else if (fifo_rd) begin
            rd_ptr <= rd_ptr + 1'b1;
         end
         if (fifo_clr) begin
            wcnt[0] <= '0; // [R25]
            wcnt[1] <= '0;
         end else begin
            if (ack_in) wcnt[tx_bank] <= '0;
            if (cancel | setup_done) wcnt[0] <= '0; // [R10]
            if (fw_wr) wcnt[fw_bank] <= wcnt[fw_bank] + 1'b1;
         end
         // Standard mode lives in bank 0; stale ping-pong bank pointers
         // would otherwise steer reads, stores and sends into bank 1
         if (!pp) begin
            fw_bank <= 1'b0;
            tx_bank <= 1'b0;
            rx_bank <= 1'b0;
            rd_bank <= 1'b0;
         end
      end
   end

   // Transaction sequencer towards the SIE
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         st <= S_IDLE;
         rx_tgt <= 1'b0;
         rx_nak <= 1'b0;
         rx_setup <= 1'b0;
         rx_took <= 1'b0;
         rx_len <= '0;
         rx_wp <= '0;
         tx_ptr <= '0;
         HS_VALID <= 1'b0;
         HS_CODE <= HS_ACK;
         TX_VALID <= 1'b0;
         TX_DATA <= 8'h00;
         TX_END <= 1'b0;
      end else begin
         HS_VALID <= 1'b0;
         TX_VALID <= 1'b0;
         TX_END <= 1'b0;
         case (st)
            S_IDLE: begin
               rx_len <= '0;
               rx_wp <= '0;
               rx_took <= 1'b0;
               tx_ptr <= '0;
               if (TOK_VALID & en) begin // [R24]
                  if ((TOK_PID == PID_SETUP) & ctrl) begin
                     st <= S_RX; // [R17]
                     rx_setup <= 1'b1;
                     rx_nak <= 1'b0;
                     rx_tgt <= 1'b0;
                  end else if ((TOK_PID == PID_OUT) & out_ok) begin
                     st <= S_RX;
                     rx_setup <= 1'b0;
                     rx_nak <= nak_out; // [R4] [R6]
                     rx_tgt <= tgt_out;
                  end else if ((TOK_PID == PID_IN) & in_ok) begin
                     if (arm[tx_bank]) begin
                        st <= S_TX;
                     end else if (!iso) begin
                        HS_VALID <= 1'b1; // [R9] [R15]
                        HS_CODE <= HS_NAK;
                     end
                  end
               end
            end
            S_RX: begin
               if (RX_VALID) rx_len <= rx_len + 1'b1; // [R7]
               if (rx_store) begin
                  rx_wp <= rx_wp + 1'b1;
                  rx_took <= 1'b1; // [R23]
               end
               if (RX_END) begin
                  st <= S_IDLE;
                  if (good) begin
                     HS_VALID <= 1'b1;
                     HS_CODE <= HS_ACK;
                  end else if (rx_nak & RX_CRC_OK) begin
                     HS_VALID <= 1'b1; // [R4]
                     HS_CODE <= HS_NAK;
                  end
               end
            end
            S_TX: begin
               if (tx_ptr < wcnt[tx_bank]) begin
                  TX_VALID <= 1'b1;
                  TX_DATA <= mem[{tx_bank, tx_ptr[AW-1:0]}];
                  tx_ptr <= tx_ptr + 1'b1;
               end else begin
                  TX_END <= 1'b1; // [R21]
                  st <= S_WACK;
               end
            end
            S_WACK: begin
               // Packet stays armed until acknowledged, so retries resend
               if (TX_ACK_IN) begin
                  st <= S_IDLE;
               end else if (TOK_VALID & en & (TOK_PID == PID_IN) & in_ok) begin
                  st <= S_TX; // [R13]
                  tx_ptr <= '0;
               end else if (TOK_VALID) begin
                  st <= S_IDLE;
               end
            end
            default: st <= S_IDLE;
         endcase
      end
   end

   // Packet buffer: two banks, receive store has priority
   always_ff @(posedge CLK) begin
      if (rx_store) begin
         mem[{rx_tgt, rx_wp[AW-1:0]}] <= RX_DATA;
      end else if (fw_wr) begin
         mem[{fw_bank, wcnt[fw_bank][AW-1:0]}] <= PWDATA[BYTE_W-1:0];
      end
   end

   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RST_N);

   sequence s_in_unarmed;
      (st == S_IDLE) && TOK_VALID && en && (TOK_PID == PID_IN) && in_ok
         && !arm[tx_bank] && !iso;
   endsequence
   sequence s_nak_out;
      (st == S_IDLE) && TOK_VALID && en && (TOK_PID == PID_OUT) && out_ok
         && full[0] && (full[1] || !pp) && !iso;
   endsequence
   sequence s_nak_end;
      (st == S_RX) && rx_nak && RX_END && RX_CRC_OK;
   endsequence

   a_in_nak_unarmed: assert property (s_in_unarmed |=> HS_VALID // [R9]
      && (HS_CODE == HS_NAK) && (st == S_IDLE))
      else $error("unarmed IN not answered with NAK");
   a_out_nak_full: assert property (s_nak_out |=> (st == S_RX) && rx_nak) // [R4]
      else $error("OUT to full bank not marked for NAK");
   a_out_nak_end: assert property (s_nak_end |=> HS_VALID // [R4]
      && (HS_CODE == HS_NAK))
      else $error("OUT to full bank not NAKed");
   a_sent_on_ack: assert property (ack_in |=> sent && (st == S_IDLE)) // [R11]
      else $error("sent flag missing after host ack");
   a_setup_clears: assert property (setup_done |=> setup // [R17]
      && (full == 2'h0) && !sent && (arm == 2'h0) && !crc)
      else $error("SETUP did not clear other flags");
   a_disabled_quiet: assert property ((st == S_IDLE) && TOK_VALID // [R24]
      && !en |=> (st == S_IDLE) && !HS_VALID)
      else $error("disabled endpoint answered");
   a_set_beats_clr: assert property (b_set[0] && b_clr[0] |=> full[0]) // [R26]
      else $error("clear overrode hardware set");
   a_crc_refresh: assert property (iso_done |=> crc == !$past(RX_CRC_OK)) // [R22]
      else $error("isochronous CRC flag not refreshed");
   a_cancel_empty: assert property (cancel |=> !arm[0] // [R10]
      && (wcnt[0] == '0))
      else $error("disarm did not empty FIFO");
   a_pp_alternate: assert property (good && pp && !rx_setup // [R5]
      |=> rx_bank != $past(rx_tgt))
      else $error("ping-pong bank did not alternate");
   a_fifo_clear: assert property (fifo_clr |=> (rd_ptr == '0) && !tgl // [R25]
      && (cnt[0] == '0) && $stable(rx_bank))
      else $error("FIFO clear incomplete");
endmodule

/* File: design/uef_pkg.sv */
// Constants for the endpoint transaction flag block.
// Assumes a 32-bit APB master and a SIE with token/data strobes.
package uef_pkg;
   // Register byte addresses
   localparam logic [7:0] A_CFG = 8'h00;
   localparam logic [7:0] A_STA = 8'h04;
   localparam logic [7:0] A_CNTL = 8'h08;
   localparam logic [7:0] A_CNTH = 8'h0C;
   localparam logic [7:0] A_DAT = 8'h10;
   localparam logic [7:0] A_CLR = 8'h14;
   // endpoint_config_reg fields
   localparam int CFG_ON = 7;
   localparam int CFG_PP = 4;
   localparam int CFG_TGL = 3;
   localparam int CFG_DIR = 2;
   localparam int CFG_TY = 0;
   // endpoint_status_reg fields
   localparam int ST_SENT = 0;
   localparam int ST_B0 = 1;
   localparam int ST_SETUP = 2;
   localparam int ST_CRC = 3;
   localparam int ST_ARM = 4;
   localparam int ST_B1 = 6;
   localparam int ST_WAY = 7;
   // endpoint_fifo_clear_reg field
   localparam int CLR_BIT = 0;
   localparam int BYTE_W = 8;
   // Endpoint types
   localparam logic [1:0] TY_CTRL = 2'h0;
   localparam logic [1:0] TY_ISO = 2'h1;
   localparam logic [1:0] TY_BULK = 2'h2;
   localparam logic [1:0] TY_INTR = 2'h3;
   // Token kinds from the SIE
   localparam logic [1:0] PID_OUT = 2'h0;
   localparam logic [1:0] PID_IN = 2'h1;
   localparam logic [1:0] PID_SETUP = 2'h2;
   // Handshake codes to the SIE
   localparam logic [1:0] HS_ACK = 2'h0;
   localparam logic [1:0] HS_NAK = 2'h1;
   typedef enum logic [1:0] {S_IDLE, S_RX, S_TX, S_WACK} uef_state_t;
endpackage
